/* rtl/cirs_params.svh */
`ifndef CIRS_PARAMS_SVH
`define CIRS_PARAMS_SVH

// Vector fetch addresses (high byte at the even address)
`define CIRS_VEC_TIMER_WAIT 13'h1ff6
`define CIRS_VEC_TIMER 13'h1ff8
`define CIRS_VEC_EXT 13'h1ffa
`define CIRS_VEC_TRAP 13'h1ffc
`define CIRS_VEC_RESET 13'h1ffe
// Power-up timeout in processor cycles
`define CIRS_POR_CYCLES 1920
`define CIRS_POR_W 11
// Stacked bytes per interrupt entry or trap return
`define CIRS_STACK_BYTES 5
`define CIRS_STK_W 3

// Register map over Wishbone (byte addresses)
`define CIRS_ADDR_CTRL 4'h0
`define CIRS_ADDR_STAT 4'h4
// Control register fields
`define CIRS_CTRL_IMASK_CLR 0
`define CIRS_CTRL_IMASK_SET 1
`define CIRS_CTRL_TREQ_CLR 2
// Status register fields
`define CIRS_STAT_IMASK 0
`define CIRS_STAT_EXT_PEND 1
`define CIRS_STAT_TIMER_PEND 2
`define CIRS_STAT_IN_RESET 3
`define CIRS_STAT_WAIT 4
`define CIRS_STAT_BUSY 5
`define CIRS_STAT_SRC_LSB 8

`endif

/* rtl/cirs_pkg.sv */
package cirs_pkg;

    // Source of the current entry sequence
    typedef enum logic [2:0] {
        CIRS_SRC_NONE,
        CIRS_SRC_RESET,
        CIRS_SRC_EXT,
        CIRS_SRC_TIMER,
        CIRS_SRC_TIMER_WAIT,
        CIRS_SRC_TRAP
    } cirs_src_t;

    // Strobes coming from the instruction sequencer
    typedef struct packed {
        logic instr_done;
        logic trap_exec;
        logic rti_exec;
        logic wait_exec;
        logic cli_exec;
        logic sei_exec;
    } cirs_core_evt_t;

    // Request to the core: push or pop one byte, or load a vector
    typedef struct packed {
        logic push;
        logic pop;
        logic vec_load;
        logic [12:0] vec_addr;
    } cirs_core_cmd_t;

endpackage

/* rtl/cirs_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for pin levels
module cirs_sync import cirs_pkg::*; #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RESET_VAL;
            q_o <= RESET_VAL;
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

/* rtl/cirs_por.sv */
`timescale 1ns/1ps
`include "cirs_params.svh"
// Power-up timeout counter, run once after power-up
module cirs_por import cirs_pkg::*; #(
    parameter int POR_CYCLES = `CIRS_POR_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic osc_ok_i,
    output logic done_o
);
    logic [`CIRS_POR_W-1:0] cnt_q;

    // Counts only once the oscillator is seen running
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            done_o <= 1'b0;
        end else if (ce_i && osc_ok_i && !done_o) begin
            if (cnt_q == `CIRS_POR_W'(POR_CYCLES - 1)) begin
                done_o <= 1'b1;
            end
            cnt_q <= cnt_q + `CIRS_POR_W'(1);
        end
    end
endmodule

/* rtl/cirs_top.sv */
// What this block does
// - Interrupt sources are external pin, timer request and software trap.
// - Interrupts are taken only at an instruction boundary.
// - Entry stacks registers, then sets the interrupt mask.
// - Return-from-trap pops the stack and resumes the interrupted program.
// - At each boundary unmasked pending hardware requests start service, else continue.
// - Masked hardware requests stay latched and are served once unmasked.
// - The interrupt mask blocks external and timer requests together.
// - External request beats timer request at the same boundary.
// - Software trap runs regardless of the interrupt mask.
// - External request pin responds to both low level and falling edge.
// - External interrupt taken while pin low and mask clear.
// - External interrupt vector lives at 1FFA/1FFB.
// - A pin still low after service raises a fresh request.
// - Reset comes from power-up or the active-low reset pin.
// - Power-up holds reset 1920 cycles after the oscillator runs.
// - Reset pin still low at timeout keeps reset until it rises.
// - Timer request raised when request flag set and both masks clear.
// - Timer interrupt vector in run state lives at 1FF8/1FF9.
// - Timer interrupt waking from wait uses vector 1FF6/1FF7.
// - Software trap stacks like an interrupt, vector at 1FFC/1FFD.
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cirs_params.svh"
module cirs_top import cirs_pkg::*; #(
    parameter int POR_CYCLES = `CIRS_POR_CYCLES,
    parameter int STACK_BYTES = `CIRS_STACK_BYTES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic osc_ok_i,
    input wire logic reset_n_i,
    input wire logic irq_n_i,
    input wire logic timer_request_flag_i,
    input wire logic timer_mask_flag_i,
    input wire cirs_core_evt_t evt_i,
    input wire logic core_ack_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic cpu_reset_o,
    output logic imask_o,
    output logic hold_fetch_o,
    output logic timer_req_clr_o,
    output cirs_core_cmd_t cmd_o,
    output cirs_src_t src_o
);
    typedef enum logic [2:0] {
        ST_RESET,
        ST_RUN,
        ST_WAIT,
        ST_PUSH,
        ST_VECTOR,
        ST_POP
    } cirs_state_t;

    cirs_state_t state_q, state_d;
    logic reset_pin_n, irq_pin_n, por_done;
    logic irq_prev_q, ext_latch_q, imask_q, in_reset_q;
    logic [`CIRS_STK_W-1:0] stk_cnt_q;
    cirs_src_t src_q;
    logic wait_q;

    // Pins cross into the clock domain through two flops each
    cirs_sync #(.RESET_VAL(1'b1)) u_sync_rst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(reset_n_i),
        .q_o(reset_pin_n)
    );
    cirs_sync #(.RESET_VAL(1'b1)) u_sync_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(irq_n_i),
        .q_o(irq_pin_n)
    );

    // rst_i stands for power-up; the pin resets the core and this block but not the timeout
    cirs_por #(.POR_CYCLES(POR_CYCLES)) u_por (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .osc_ok_i(osc_ok_i),
        .done_o(por_done)
    );

    // Reset held by timeout or by a low pin
    wire reset_hold = !por_done || !reset_pin_n;

    // Register bus decode
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    wire sel_ctrl = wb_adr_i == `CIRS_ADDR_CTRL;
    wire sel_stat = wb_adr_i == `CIRS_ADDR_STAT;
    wire sw_imask_clr = wb_wr && sel_ctrl && wb_dat_i[`CIRS_CTRL_IMASK_CLR];
    wire sw_imask_set = wb_wr && sel_ctrl && wb_dat_i[`CIRS_CTRL_IMASK_SET];
    wire sw_treq_clr = wb_wr && sel_ctrl && wb_dat_i[`CIRS_CTRL_TREQ_CLR];

    // Falling edge on the synchronised request pin
    wire irq_fall = irq_prev_q && !irq_pin_n;

    // Pending sources, with level and latched edge both counted
    wire ext_pend = !irq_pin_n || ext_latch_q;
    wire timer_pend = timer_request_flag_i && !timer_mask_flag_i;
    wire hw_take = !imask_q && (ext_pend || timer_pend);
    wire at_boundary = state_q == ST_RUN && evt_i.instr_done;
    wire take_hw = at_boundary && hw_take;
    wire take_trap = at_boundary && !hw_take && evt_i.trap_exec;
    wire take_rti = at_boundary && !hw_take && !evt_i.trap_exec && evt_i.rti_exec;
    wire wake = state_q == ST_WAIT && hw_take;

    // Source selection with fixed external priority
    cirs_src_t hw_src;
    assign hw_src = ext_pend ? CIRS_SRC_EXT : (wait_q ? CIRS_SRC_TIMER_WAIT : CIRS_SRC_TIMER);

    // Vector for the selected source
    logic [12:0] vec_addr;
    always_comb begin
        unique case (src_q)
            CIRS_SRC_EXT: vec_addr = `CIRS_VEC_EXT;
            CIRS_SRC_TIMER: vec_addr = `CIRS_VEC_TIMER;
            CIRS_SRC_TIMER_WAIT: vec_addr = `CIRS_VEC_TIMER_WAIT;
            CIRS_SRC_TRAP: vec_addr = `CIRS_VEC_TRAP;
            default: vec_addr = `CIRS_VEC_RESET;
        endcase
    end

    wire stk_last = stk_cnt_q == `CIRS_STK_W'(STACK_BYTES - 1);

    // Sequencer: stack first, mask after, vector last
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RESET: if (!reset_hold) state_d = ST_VECTOR;
            ST_RUN: begin
                if (take_hw || take_trap) begin
                    state_d = ST_PUSH;
                end else if (take_rti) begin
                    state_d = ST_POP;
                end else if (at_boundary && evt_i.wait_exec) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: if (wake) state_d = ST_PUSH;
            ST_PUSH: if (core_ack_i && stk_last) state_d = ST_VECTOR;
            ST_VECTOR: if (core_ack_i) state_d = ST_RUN;
            ST_POP: if (core_ack_i && stk_last) state_d = ST_RUN;
        endcase
    end

    // State, source and stack byte counter
    always_ff @(posedge clk_i) begin
        if (rst_i || reset_hold) begin
            state_q <= ST_RESET;
            src_q <= CIRS_SRC_RESET;
            stk_cnt_q <= '0;
            wait_q <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            if (take_hw || wake) begin
                src_q <= hw_src;
            end else if (take_trap) begin
                src_q <= CIRS_SRC_TRAP;
            end
            if (at_boundary && evt_i.wait_exec && !hw_take) begin
                wait_q <= 1'b1;
            end else if (state_q == ST_VECTOR) begin
                wait_q <= 1'b0; // Later timer service uses the run vector
            end
            if ((state_q == ST_PUSH || state_q == ST_POP) && core_ack_i) begin
                stk_cnt_q <= stk_last ? '0 : stk_cnt_q + `CIRS_STK_W'(1);
            end
        end
    end

    // Edge latch: set beats the clear taken on external entry
    always_ff @(posedge clk_i) begin
        if (rst_i || reset_hold) begin
            irq_prev_q <= 1'b1;
            ext_latch_q <= 1'b0;
        end else if (ce_i) begin
            irq_prev_q <= irq_pin_n;
            if (irq_fall) begin
                ext_latch_q <= 1'b1;
            end else if ((take_hw || wake) && hw_src == CIRS_SRC_EXT) begin
                ext_latch_q <= 1'b0;
            end
        end
    end

    // Interrupt mask: set on reset and after stacking
    wire push_done = state_q == ST_PUSH && core_ack_i && stk_last;
    always_ff @(posedge clk_i) begin
        if (rst_i || reset_hold) begin
            imask_q <= 1'b1;
        end else if (ce_i) begin
            if (push_done || sw_imask_set || evt_i.sei_exec) begin
                imask_q <= 1'b1;
            end else if (sw_imask_clr || evt_i.cli_exec) begin
                imask_q <= 1'b0;
            end
        end
    end

    // Registered outputs toward the core
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_reset_q <= 1'b1;
            cpu_reset_o <= 1'b1;
            imask_o <= 1'b1;
            hold_fetch_o <= 1'b1;
            timer_req_clr_o <= 1'b0;
            cmd_o <= '0;
            src_o <= CIRS_SRC_NONE;
        end else if (ce_i) begin
            in_reset_q <= reset_hold;
            cpu_reset_o <= reset_hold;
            imask_o <= imask_q;
            hold_fetch_o <= state_d != ST_RUN;
            timer_req_clr_o <= sw_treq_clr;
            cmd_o.push <= state_d == ST_PUSH;
            cmd_o.pop <= state_d == ST_POP;
            cmd_o.vec_load <= state_d == ST_VECTOR;
            cmd_o.vec_addr <= vec_addr;
            src_o <= src_q;
        end
    end

    // Status word read back by software
    logic [31:0] stat_word;
    always_comb begin
        stat_word = '0;
        stat_word[`CIRS_STAT_IMASK] = imask_q;
        stat_word[`CIRS_STAT_EXT_PEND] = ext_pend;
        stat_word[`CIRS_STAT_TIMER_PEND] = timer_pend;
        stat_word[`CIRS_STAT_IN_RESET] = in_reset_q;
        stat_word[`CIRS_STAT_WAIT] = wait_q;
        stat_word[`CIRS_STAT_BUSY] = state_q != ST_RUN;
        stat_word[`CIRS_STAT_SRC_LSB +: 3] = src_q;
    end

    wire [31:0] rd_word = sel_stat ? stat_word : 32'h0000_0000;

    // Wishbone slave: one wait state, ack held one cycle, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req && !wb_we_i) ? rd_word : 32'h0000_0000;
        end
    end
endmodule

/* dv/cirs_top_checker.sv */
`timescale 1ns/1ps
`include "cirs_params.svh"
module cirs_top_checker import cirs_pkg::*; #(
    parameter int STACK_BYTES = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cirs_core_evt_t evt_i,
    input wire logic core_ack_i,
    input wire logic cpu_reset_o,
    input wire logic imask_o,
    input wire logic hold_fetch_o,
    input wire cirs_core_cmd_t cmd_o,
    input wire cirs_src_t src_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [3:0] acks_q;
    // Stack acks since the last vector; a short stack would corrupt the return
    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_o.vec_load) begin
            acks_q <= 4'h0;
        end else if (cmd_o.push && core_ack_i) begin
            acks_q <= acks_q + 4'h1;
        end
    end
    a_reset_sets_mask: assert property ($fell(rst_i) |-> imask_o && cpu_reset_o && hold_fetch_o)
        else $error("mask or core reset clear after reset");
    a_ext_vector: assert property (cmd_o.vec_load && src_o == CIRS_SRC_EXT |-> cmd_o.vec_addr == `CIRS_VEC_EXT)
        else $error("bad external vector");
    a_timer_vector: assert property (cmd_o.vec_load && src_o == CIRS_SRC_TIMER |-> cmd_o.vec_addr == `CIRS_VEC_TIMER)
        else $error("bad timer vector");
    a_wake_vector: assert property (cmd_o.vec_load && src_o == CIRS_SRC_TIMER_WAIT
        |-> cmd_o.vec_addr == `CIRS_VEC_TIMER_WAIT)
        else $error("bad wake vector");
    a_trap_vector: assert property (cmd_o.vec_load && src_o == CIRS_SRC_TRAP |-> cmd_o.vec_addr == `CIRS_VEC_TRAP)
        else $error("bad trap vector");
    // Mask output trails the internal flag by one register stage
    a_mask_at_vector: assert property ($rose(cmd_o.vec_load) |-> hold_fetch_o ##1 imask_o)
        else $error("mask clear at vector fetch");
    a_masked_no_entry: assert property (evt_i.instr_done && imask_o && !hold_fetch_o && !evt_i.trap_exec
        && !evt_i.wait_exec |=> !cmd_o.push)
        else $error("entry while masked");
    a_stack_before_vec: assert property ($rose(cmd_o.vec_load) && src_o != CIRS_SRC_RESET
        |-> acks_q == 4'(STACK_BYTES))
        else $error("vector before full stack");
endmodule
bind cirs_top cirs_top_checker #(.STACK_BYTES(STACK_BYTES)) cirs_top_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .evt_i(evt_i), .core_ack_i(core_ack_i), .cpu_reset_o(cpu_reset_o), .imask_o(imask_o),
    .hold_fetch_o(hold_fetch_o), .cmd_o(cmd_o), .src_o(src_o));

/* dv/cirs_core_model.sv */
`timescale 1ns/1ps
module cirs_core_model import cirs_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire cirs_core_cmd_t cmd_i,
    output logic core_ack_o
);
    logic [1:0] dly_q;
    logic [12:0] last_vec_q;
    int vecs_q;
    wire logic busy = cmd_i.push | cmd_i.pop | cmd_i.vec_load;
    // One ack per byte, idle after it so the block sees each step apart
    always_ff @(posedge clk_i) begin
        if (rst_i || core_ack_o || !busy) begin
            core_ack_o <= 1'b0;
            dly_q <= slow_i ? 2'h2 : 2'h0;
        end else if (dly_q != 2'h0) begin
            dly_q <= dly_q - 2'h1;
        end else begin
            core_ack_o <= 1'b1;
        end
    end
    // Vector fetches seen by the core
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vecs_q <= 0;
        end else if (core_ack_o && cmd_i.vec_load) begin
            vecs_q <= vecs_q + 1;
            last_vec_q <= cmd_i.vec_addr;
        end
    end
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
`include "cirs_params.svh"
module tb import cirs_pkg::*;;
    localparam cirs_core_evt_t ev_done = 6'h20;
    localparam cirs_core_evt_t ev_trap = 6'h30;
    localparam cirs_core_evt_t ev_rti = 6'h28;
    localparam cirs_core_evt_t ev_wait = 6'h24;
    logic clk = 1'b0, rst = 1'b1, osc_ok = 1'b0, pin_n = 1'b1, irq_n = 1'b1;
    logic treq = 1'b0, tmask = 1'b0, slow = 1'b0, cyc = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, rd, rdat;
    logic wack, ack, cpu_rst, imask, hold, treq_clr;
    cirs_core_evt_t evt = '0;
    cirs_core_cmd_t cmd;
    cirs_src_t src;
    int fail_count = 0, checks_done = 0, cycles = 0, clr_seen = 0;
    always #12.5 clk = ~clk;
    // Short power-up count keeps the run brief
    cirs_top #(.POR_CYCLES(8)) cirs_top_i (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .osc_ok_i(osc_ok),
        .reset_n_i(pin_n), .irq_n_i(irq_n), .timer_request_flag_i(treq), .timer_mask_flag_i(tmask),
        .evt_i(evt), .core_ack_i(ack), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(wack), .cpu_reset_o(cpu_rst),
        .imask_o(imask), .hold_fetch_o(hold), .timer_req_clr_o(treq_clr), .cmd_o(cmd), .src_o(src));
    cirs_core_model cirs_core_model_i (.clk_i(clk), .rst_i(rst), .slow_i(slow), .cmd_i(cmd), .core_ack_o(ack));
    // Counts clear pulses; a pulse lasts one cycle and is easy to miss by polling
    always @(posedge clk) begin
        if (treq_clr === 1'b1) begin
            clr_seen <= clr_seen + 1;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Single bus cycle, held until ack is sampled, then idle for one cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        @(posedge clk);
        while (wack !== 1'b1) @(posedge clk);
        rdat = rd;
        cyc <= 1'b0;
        @(posedge clk);
    endtask
    task automatic mask(input logic [31:0] d);
        wb(1'b1, `CIRS_ADDR_CTRL, 4'hf, d);
    endtask
    // Optional event, then wait for a vector fetch and the end of the sequence
    task automatic enter(input cirs_core_evt_t e, input logic took, input cirs_src_t s, input logic [12:0] v);
        int n0;
        n0 = cirs_core_model_i.vecs_q;
        if (e != '0) begin
            evt <= e;
            @(posedge clk);
            evt <= '0;
        end
        for (int i = 0; i < 60 && cirs_core_model_i.vecs_q == n0; i++) @(posedge clk);
        while (hold === 1'b1 && cirs_core_model_i.vecs_q != n0) @(posedge clk);
        chk(32'(cirs_core_model_i.vecs_q - n0), 32'(took));
        if (took) begin
            chk(32'(src), 32'(s));
            chk(32'(cirs_core_model_i.last_vec_q), 32'(v));
            chk(32'(imask), 32'h1);
        end
    endtask
    task automatic t_power_up;
        int n;
        n = 0;
        tick(5);
        chk(32'(cpu_rst), 32'h1);
        osc_ok <= 1'b1;
        while (cpu_rst === 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= 8 && n <= 12), 32'h1);
        enter('0, 1'b1, CIRS_SRC_RESET, `CIRS_VEC_RESET);
        $display("power-up test done");
    endtask
    task automatic t_ext;
        slow <= 1'b1;
        wb(1'b1, `CIRS_ADDR_CTRL, 4'h0, 32'h1);
        wb(1'b0, `CIRS_ADDR_STAT, 4'hf, 32'h0);
        chk(32'(rdat[0]), 32'h1);
        irq_n <= 1'b0;
        mask(32'h1);
        enter(ev_done, 1'b1, CIRS_SRC_EXT, `CIRS_VEC_EXT);
        enter(ev_rti, 1'b0, CIRS_SRC_EXT, 13'h0);
        mask(32'h1);
        enter(ev_done, 1'b1, CIRS_SRC_EXT, `CIRS_VEC_EXT);
        irq_n <= 1'b1;
        enter(ev_rti, 1'b0, CIRS_SRC_EXT, 13'h0);
        slow <= 1'b0;
        $display("external request test done");
    endtask
    task automatic t_masked;
        int n;
        mask(32'h2);
        treq <= 1'b1;
        irq_n <= 1'b0;
        tick(2);
        irq_n <= 1'b1;
        enter(ev_done, 1'b0, CIRS_SRC_EXT, 13'h0);
        wb(1'b0, `CIRS_ADDR_STAT, 4'hf, 32'h0);
        chk(32'(rdat[1]), 32'h1);
        mask(32'h1);
        enter(ev_done, 1'b1, CIRS_SRC_EXT, `CIRS_VEC_EXT);
        enter(ev_rti, 1'b0, CIRS_SRC_EXT, 13'h0);
        mask(32'h1);
        enter(ev_done, 1'b1, CIRS_SRC_TIMER, `CIRS_VEC_TIMER);
        treq <= 1'b0;
        enter(ev_rti, 1'b0, CIRS_SRC_TIMER, 13'h0);
        tmask <= 1'b1;
        treq <= 1'b1;
        mask(32'h1);
        enter(ev_done, 1'b0, CIRS_SRC_TIMER, 13'h0);
        treq <= 1'b0;
        tmask <= 1'b0;
        n = clr_seen;
        wb(1'b1, `CIRS_ADDR_CTRL, 4'hf, 32'h4);
        tick(2);
        chk(32'(clr_seen - n), 32'h1);
        $display("masked request test done");
    endtask
    task automatic t_trap_wait;
        mask(32'h2);
        enter(ev_trap, 1'b1, CIRS_SRC_TRAP, `CIRS_VEC_TRAP);
        enter(ev_rti, 1'b0, CIRS_SRC_TRAP, 13'h0);
        mask(32'h1);
        enter(ev_wait, 1'b0, CIRS_SRC_TRAP, 13'h0);
        treq <= 1'b1;
        enter('0, 1'b1, CIRS_SRC_TIMER_WAIT, `CIRS_VEC_TIMER_WAIT);
        treq <= 1'b0;
        enter(ev_rti, 1'b0, CIRS_SRC_TIMER_WAIT, 13'h0);
        $display("trap and wait test done");
    endtask
    task automatic t_pin;
        int n;
        n = 0;
        pin_n <= 1'b0;
        tick(3);
        pin_n <= 1'b1;
        while (cpu_rst !== 1'b1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        chk(32'(cpu_rst), 32'h1);
        enter('0, 1'b1, CIRS_SRC_RESET, `CIRS_VEC_RESET);
        pin_n <= 1'b0;
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(30);
        chk(32'(cpu_rst), 32'h1);
        pin_n <= 1'b1;
        enter('0, 1'b1, CIRS_SRC_RESET, `CIRS_VEC_RESET);
        $display("reset pin test done");
    endtask
    // Hang guard, far above the thousand or so cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        tick(20);
        rst <= 1'b0;
        t_power_up();
        t_ext();
        t_masked();
        t_trap_wait();
        t_pin();
        tally_and_finish();
    end
endmodule
